/* File: include/cd_play_params.svh */
// Purpose: constants of the disc play-state controller
// Assumes: 100 MHz clock
// Notes: definitions only
`ifndef CD_PLAY_PARAMS_SVH
`define CD_PLAY_PARAMS_SVH
`define CDP_CLK_NS 10
`define CDP_STD_NS 13300000
`define CDP_DBL_NS 6700000
`define CDP_OTH_NS 16700000
`define CDP_SEC_NS 1000000000
// cadences round down so no slot is ever late
`define CDP_STD_CYC (`CDP_STD_NS / `CDP_CLK_NS)
`define CDP_DBL_CYC (`CDP_DBL_NS / `CDP_CLK_NS)
`define CDP_OTH_CYC (`CDP_OTH_NS / `CDP_CLK_NS)
`define CDP_SEC_CYC (`CDP_SEC_NS / `CDP_CLK_NS)
`define CDP_FAD_W 24
`define CDP_REP_W 4
`define CDP_TMR_W 24
`define CDP_REP_CAP 4'he
`define CDP_REP_RST 4'h0
`define CDP_MAX_RST 4'h0
`define CDP_DISC_START 24'h000096
`define CDP_FAD_RST 24'h000096
`define CDP_FF_FAD 24'hffffff
`define CDP_FF_REP 4'hf
`define CDP_SBY_DEF 16'h0000
`define CDP_SBY_DEF_SEC 16'h00b4
`define CDP_SBY_MIN 16'h003c
`define CDP_SBY_MAX 16'h0384
`define CDP_CODE_BUSY 4'h0
`define CDP_CODE_PAUSE 4'h1
`define CDP_CODE_STANDBY 4'h2
`define CDP_CODE_PLAY 4'h3
`endif

/* File: include/cd_play_pkg.sv */
// Purpose: types of the disc play-state controller
// Assumes: nothing
// Notes: gray codes along standby, busy, play, pause
package cd_play_pkg;
	typedef enum logic [1:0] {
		ST_STANDBY = 2'b00,
		ST_BUSY = 2'b01,
		ST_PLAY = 2'b11,
		ST_PAUSE = 2'b10
	} drive_state_e;
endpackage

/* File: rtl/cd_play_state_controller.sv */
// Purpose: play-state controller of an optical-disc drive
// Assumes: all inputs come from logic on clock_i; commands are pulses
// Notes: drive mechanics report through sector_read_i and seek_done_i
// How it works
// - refresh report each drive slot, speed-dependent
// - hold report during command or response handling
// - after response read, refresh at next slot
// - address names sector now being read
// - play end leaves address at end plus one
// - pause reports last buffered sector plus one
// - repeat check when position leaves range
// - four-bit counts; repeat count caps at E
// - below maximum: seek start, play, count up
// - at maximum: pause here, raise play-end flag
// - range or maximum change clears repeat count
// - play in range plays without moving pickup
// - no repeat: pause, end flag on play end
// - seek or scan out of range pauses
// - home seek: motor off, standby, report all ones
// - home standby to pause moves to disc start
// - standby from pause keeps position and report
// - buffer full pauses and raises buffer-full flag
// - standby timeout setting decode, default 180 s
// - data reads never run at standard speed
`include "cd_play_params.svh"
module cd_play_state_controller
	import cd_play_pkg::*;
#(
	parameter int STD_CYC = `CDP_STD_CYC,
	parameter int DBL_CYC = `CDP_DBL_CYC,
	parameter int OTH_CYC = `CDP_OTH_CYC,
	parameter int SEC_CYC = `CDP_SEC_CYC
) (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic cmd_play_i,
	input wire logic cmd_pause_i,
	input wire logic cmd_seek_i,
	input wire logic cmd_scan_i,
	input wire logic cmd_home_i,
	input wire logic cmd_standby_i,
	input wire logic range_set_i,
	input wire logic [23:0] range_start_i,
	input wire logic [23:0] range_end_i,
	input wire logic max_repeat_set_i,
	input wire logic [3:0] max_repeat_i,
	input wire logic [23:0] seek_fad_i,
	input wire logic sector_read_i,
	input wire logic buffer_full_i,
	input wire logic seek_done_i,
	input wire logic data_mode_i,
	input wire logic double_speed_i,
	input wire logic standby_time_set_i,
	input wire logic [15:0] standby_time_i,
	input wire logic resp_read_i,
	input wire logic play_end_clr_i,
	input wire logic buffer_full_clr_i,
	input wire logic subcode_q_clr_i,
	output logic [3:0] status_code_o,
	output logic [23:0] frame_address_o,
	output logic [3:0] repeat_count_o,
	output logic periodic_valid_o,
	output logic resp_pending_o,
	output logic play_end_flag_o,
	output logic buffer_full_flag_o,
	output logic subcode_q_ready_flag_o,
	output logic double_rate_o,
	output logic motor_on_o
);
	drive_state_e state_reg, state_next, after_reg, after_next;
	logic [23:0] fad_reg, fad_next, start_reg, end_reg;
	logic [3:0] max_reg, rep_reg;
	logic home_reg, home_next, motor_next;
	logic [23:0] rng_start, rng_end;
	logic [3:0] rep_eff, max_eff;
	logic cmd_ok, pri_clear, play_take, set_rng;
	logic in_range, seek_in, can_repeat;
	logic repeat_go, play_end_flag_set, buffer_full_flag_set, end_take, home_take, cmd_any;
	logic fast, tick, sby_expire, refresh;
	logic [23:0] period;

	// commands other than home are dropped during a busy seek
	assign cmd_ok = (state_reg != ST_BUSY);
	assign home_take = cmd_home_i;
	assign pri_clear = cmd_ok && !cmd_home_i && !cmd_standby_i && !cmd_seek_i
		&& !cmd_scan_i && !cmd_pause_i;
	assign play_take = pri_clear && cmd_play_i;
	assign set_rng = play_take && range_set_i;
	assign cmd_any = cmd_play_i | cmd_pause_i | cmd_seek_i | cmd_scan_i
		| cmd_home_i | cmd_standby_i;
	assign end_take = pri_clear && !cmd_play_i && state_reg == ST_PLAY
		&& !buffer_full_i && sector_read_i && fad_reg == end_reg;

	always_comb begin
		rng_start = set_rng ? range_start_i : start_reg;
		rng_end = set_rng ? range_end_i : end_reg;
		max_eff = max_repeat_set_i ? max_repeat_i : max_reg;
		rep_eff = (set_rng || max_repeat_set_i) ? `CDP_REP_RST : rep_reg;
		can_repeat = (rep_eff < max_eff);
		in_range = (fad_reg >= rng_start) && (fad_reg <= rng_end);
		seek_in = (seek_fad_i >= rng_start) && (seek_fad_i <= rng_end);
	end

	// one decision point for every transition; priority runs top down
	always_comb begin
		state_next = state_reg;
		after_next = after_reg;
		fad_next = fad_reg;
		home_next = home_reg;
		motor_next = motor_on_o;
		repeat_go = 1'b0;
		play_end_flag_set = 1'b0;
		buffer_full_flag_set = 1'b0;
		if (home_take) begin
			state_next = ST_BUSY;
			after_next = ST_STANDBY;
			home_next = 1'b1;
			motor_next = 1'b0;
		end else if (!cmd_ok) begin
			if (seek_done_i) begin
				state_next = after_reg;
			end
		end else if (cmd_standby_i) begin
			if (state_reg == ST_PAUSE) begin
				state_next = ST_STANDBY;
			end
		end else if (cmd_seek_i) begin
			state_next = ST_BUSY;
			after_next = ST_PAUSE;
			fad_next = seek_fad_i;
			home_next = 1'b0;
			motor_next = 1'b1;
			play_end_flag_set = !seek_in && !can_repeat;
		end else if (cmd_scan_i) begin
			state_next = ST_PAUSE;
			play_end_flag_set = !in_range && !can_repeat;
		end else if (cmd_pause_i) begin
			if (home_reg) begin
				state_next = ST_BUSY;
				after_next = ST_PAUSE;
				fad_next = `CDP_DISC_START;
				home_next = 1'b0;
				motor_next = 1'b1;
			end else begin
				// fad already names the sector after the last buffered one
				state_next = ST_PAUSE;
			end
		end else if (cmd_play_i) begin
			if (home_reg) begin
				state_next = ST_BUSY;
				after_next = ST_PLAY;
				fad_next = rng_start;
				home_next = 1'b0;
				motor_next = 1'b1;
			end else if (in_range) begin
				state_next = ST_PLAY;
				motor_next = 1'b1;
			end else if (can_repeat) begin
				repeat_go = 1'b1;
				state_next = ST_BUSY;
				after_next = ST_PLAY;
				fad_next = rng_start;
				motor_next = 1'b1;
			end else begin
				state_next = ST_PAUSE;
				play_end_flag_set = 1'b1;
			end
		end else if (state_reg == ST_PLAY && buffer_full_i) begin
			state_next = ST_PAUSE;
			buffer_full_flag_set = 1'b1;
		end else if (state_reg == ST_PLAY && sector_read_i) begin
			fad_next = fad_reg + 24'h000001;
			if (end_take) begin
				if (can_repeat) begin
					repeat_go = 1'b1;
					state_next = ST_BUSY;
					after_next = ST_PLAY;
					fad_next = rng_start;
				end else begin
					state_next = ST_PAUSE;
					play_end_flag_set = 1'b1;
				end
			end
		end else if (state_reg == ST_PAUSE && sby_expire) begin
			state_next = ST_STANDBY;
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg <= ST_STANDBY;
			after_reg <= ST_STANDBY;
			fad_reg <= `CDP_FAD_RST;
			home_reg <= 1'b1;
			motor_on_o <= 1'b0;
		end else begin
			state_reg <= state_next;
			after_reg <= after_next;
			fad_reg <= fad_next;
			home_reg <= home_next;
			motor_on_o <= motor_next;
		end
	end

	// range and maximum survive home seeks and plain seeks
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			start_reg <= `CDP_FAD_RST;
			end_reg <= `CDP_FAD_RST;
			max_reg <= `CDP_MAX_RST;
		end else begin
			if (set_rng) begin
				start_reg <= range_start_i;
				end_reg <= range_end_i;
			end
			if (max_repeat_set_i) begin
				max_reg <= max_repeat_i;
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rep_reg <= `CDP_REP_RST;
		end else if (repeat_go && rep_eff < `CDP_REP_CAP) begin
			rep_reg <= rep_eff + 4'h1;
		end else begin
			rep_reg <= rep_eff;
		end
	end

	// set wins over clear on every flag
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			play_end_flag_o <= 1'b0;
			buffer_full_flag_o <= 1'b0;
		end else begin
			play_end_flag_o <= play_end_flag_set | (play_end_flag_o & ~play_end_clr_i);
			buffer_full_flag_o <= buffer_full_flag_set | (buffer_full_flag_o & ~buffer_full_clr_i);
		end
	end

	// data reads have no standard-speed choice
	assign fast = data_mode_i | double_speed_i;

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			double_rate_o <= 1'b1;
		end else begin
			double_rate_o <= fast;
		end
	end

	always_comb begin
		if (state_reg == ST_PLAY) begin
			period = fast ? 24'(DBL_CYC) : 24'(STD_CYC);
		end else begin
			period = 24'(OTH_CYC);
		end
	end

	period_timer #(.W(`CDP_TMR_W)) u_slot (
		.clock_i(clock_i), .rst_b_i(rst_b_i), .period_i(period), .tick_o(tick));
	standby_timer #(.SEC_CYC(SEC_CYC)) u_sby (
		.clock_i(clock_i), .rst_b_i(rst_b_i), .run_i(state_reg == ST_PAUSE),
		.setting_i(standby_time_i), .setting_load_i(standby_time_set_i),
		.expire_o(sby_expire));

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			resp_pending_o <= 1'b0;
		end else begin
			resp_pending_o <= cmd_any | (resp_pending_o & ~resp_read_i);
		end
	end

	// a slot that meets a command or an unread response is skipped
	assign refresh = tick && !resp_pending_o && !cmd_any;

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			status_code_o <= `CDP_CODE_STANDBY;
			frame_address_o <= `CDP_FF_FAD;
			repeat_count_o <= `CDP_FF_REP;
		end else if (refresh) begin
			case (state_reg)
				ST_BUSY: status_code_o <= `CDP_CODE_BUSY;
				ST_PAUSE: status_code_o <= `CDP_CODE_PAUSE;
				ST_PLAY: status_code_o <= `CDP_CODE_PLAY;
				default: status_code_o <= `CDP_CODE_STANDBY;
			endcase
			frame_address_o <= home_reg ? `CDP_FF_FAD : fad_reg;
			repeat_count_o <= home_reg ? `CDP_FF_REP : rep_reg;
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			periodic_valid_o <= 1'b0;
		end else if (refresh) begin
			periodic_valid_o <= 1'b1;
		end else if (cmd_any) begin
			periodic_valid_o <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			subcode_q_ready_flag_o <= 1'b0;
		end else begin
			subcode_q_ready_flag_o <= refresh | (subcode_q_ready_flag_o & ~subcode_q_clr_i);
		end
	end

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_b_i);
	sequence s_home_cmd;
		home_take;
	endsequence
	sequence s_home_done;
		state_reg == ST_BUSY && !motor_on_o && home_reg;
	endsequence
	property p_hold;
		resp_pending_o |=> $stable(frame_address_o) && $stable(status_code_o);
	endproperty
	a_hold: assert property (p_hold) else $error("report moved while held");
	property p_valid_slot;
		$rose(periodic_valid_o) |-> $past(tick) && !$past(resp_pending_o);
	endproperty
	a_valid_slot: assert property (p_valid_slot) else $error("report outside slot");
	property p_sq_flag;
		$rose(periodic_valid_o) |-> subcode_q_ready_flag_o;
	endproperty
	a_sq_flag: assert property (p_sq_flag) else $error("subcode flag not set");
	property p_buffer_full_flag;
		buffer_full_flag_set |=> state_reg == ST_PAUSE && buffer_full_flag_o;
	endproperty
	a_buffer_full_flag: assert property (p_buffer_full_flag) else $error("buffer full mishandled");
	property p_end;
		end_take && !repeat_go |=> state_reg == ST_PAUSE && play_end_flag_o
			&& fad_reg == $past(end_reg) + 24'h000001;
	endproperty
	a_end: assert property (p_end) else $error("play end mishandled");
	property p_repeat;
		repeat_go |=> state_reg == ST_BUSY && fad_reg == $past(rng_start);
	endproperty
	a_repeat: assert property (p_repeat) else $error("repeat seek wrong");
	property p_rep_cap;
		rep_reg <= `CDP_REP_CAP;
	endproperty
	a_rep_cap: assert property (p_rep_cap) else $error("repeat count past cap");
	property p_rng_clear;
		set_rng && !repeat_go |=> rep_reg == `CDP_REP_RST;
	endproperty
	a_rng_clear: assert property (p_rng_clear) else $error("repeat count kept");
	property p_home;
		s_home_cmd |=> s_home_done;
	endproperty
	a_home: assert property (p_home) else $error("home seek wrong");
	property p_home_keep;
		home_take && !max_repeat_set_i |=> $stable(start_reg) && $stable(rep_reg);
	endproperty
	a_home_keep: assert property (p_home_keep) else $error("home lost range");
endmodule

/* File: rtl/period_timer.sv */
// Purpose: free-running slot timer, one tick per period
// Assumes: period_i is at least 2
// Notes: a new period takes effect at the next reload
module period_timer #(
	parameter int W = 24
) (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic [W-1:0] period_i,
	output logic tick_o
);
	logic [W-1:0] cnt_reg;

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_reg <= '0;
			tick_o <= 1'b0;
		end else if (cnt_reg == '0) begin
			cnt_reg <= period_i - W'(1);
			tick_o <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg - W'(1);
			tick_o <= 1'b0;
		end
	end
endmodule

/* File: rtl/standby_timer.sv */
// Purpose: pause-to-standby timeout in whole seconds
// Assumes: run_i drops once expire_o has been acted on
// Notes: zero loads the 180 s default; other out-of-range settings are ignored and keep the old limit
`include "cd_play_params.svh"
module standby_timer #(
	parameter int SEC_CYC = `CDP_SEC_CYC
) (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic run_i,
	input wire logic [15:0] setting_i,
	input wire logic setting_load_i,
	output logic expire_o
);
	logic [15:0] limit_reg;
	logic [31:0] presc_reg;
	logic [15:0] sec_reg;
	logic sec_end;

	assign sec_end = (presc_reg == 32'(SEC_CYC - 1));

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			limit_reg <= `CDP_SBY_DEF_SEC;
		end else if (setting_load_i) begin
			if (setting_i == `CDP_SBY_DEF) begin
				limit_reg <= `CDP_SBY_DEF_SEC;
			end else if (setting_i >= `CDP_SBY_MIN && setting_i <= `CDP_SBY_MAX) begin
				limit_reg <= setting_i;
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			presc_reg <= '0;
			sec_reg <= '0;
			expire_o <= 1'b0;
		end else if (!run_i) begin
			presc_reg <= '0;
			sec_reg <= '0;
			expire_o <= 1'b0;
		end else if (sec_end) begin
			presc_reg <= '0;
			sec_reg <= sec_reg + 16'h0001;
			expire_o <= (sec_reg + 16'h0001 == limit_reg);
		end else begin
			presc_reg <= presc_reg + 32'h1;
			expire_o <= 1'b0;
		end
	end
endmodule

/* File: verif/cd_host_drive_model.sv */
// Purpose: host and drive-mechanics stand-in for the play controller
// Assumes: the bench kicks a seek only while the controller is busy
// Notes: seek latency comes per seek from the bench, so prompt and slow drives both occur
module cd_host_drive_model (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic seek_kick_i,
	input wire logic [7:0] lat_i,
	input wire logic resp_pending_i,
	input wire logic auto_read_i,
	output logic seek_done_o,
	output logic resp_read_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_reg;
	logic run_reg;
	logic [1:0] think_reg;
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_reg <= 8'h00;
			run_reg <= 1'b0;
			seek_done_o <= 1'b0;
		end else begin
			seek_done_o <= 1'b0;
			if (seek_kick_i) begin
				cnt_reg <= lat_i;
				run_reg <= 1'b1;
			end else if (run_reg && cnt_reg == 8'h00) begin
				seek_done_o <= 1'b1;
				run_reg <= 1'b0;
			end else if (run_reg) begin
				cnt_reg <= cnt_reg - 8'h01;
			end
		end
	end
	// the host reads each response after a short think time and never issues stop
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			think_reg <= 2'h0;
			resp_read_o <= 1'b0;
		end else begin
			resp_read_o <= 1'b0;
			if (auto_read_i && resp_pending_i && !resp_read_o) begin
				think_reg <= think_reg + 2'h1;
				if (think_reg == 2'h3) begin
					resp_read_o <= 1'b1;
				end
			end else begin
				think_reg <= 2'h0;
			end
		end
	end
endmodule

/* File: verif/cd_play_state_controller_bench.sv */
// Purpose: self-checking bench of the play-state controller
// Assumes: short cadence and second counts through parameters
// Notes: report checks wait two slow slots, since a new cadence applies only at reload
module cd_play_state_controller_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int STD = 40;
	localparam int DBL = 20;
	localparam int OTH = 50;
	localparam int SEC = 100;
	logic clock_i, rst_b_i, rset, mset, sread, bfull, dmode, dspeed, tset;
	logic pe_clr, bf_clr, sq_clr, kick, auto_rd, sdone, rread;
	logic valid, play_end_flag, pef, bff, sqf, drate, motor;
	logic [5:0] cmd_v;
	logic [23:0] rs, re, sfad, fad;
	logic [3:0] mrep, st, rep;
	logic [15:0] tval;
	logic [7:0] lat;
	int failures, n_tests, len, n;
	cd_play_state_controller #(.STD_CYC(STD), .DBL_CYC(DBL), .OTH_CYC(OTH), .SEC_CYC(SEC)) u_dut (
		.clock_i(clock_i), .rst_b_i(rst_b_i), .cmd_play_i(cmd_v[0]), .cmd_pause_i(cmd_v[1]),
		.cmd_seek_i(cmd_v[2]), .cmd_scan_i(cmd_v[3]), .cmd_home_i(cmd_v[4]),
		.cmd_standby_i(cmd_v[5]), .range_set_i(rset), .range_start_i(rs), .range_end_i(re),
		.max_repeat_set_i(mset), .max_repeat_i(mrep), .seek_fad_i(sfad), .sector_read_i(sread),
		.buffer_full_i(bfull), .seek_done_i(sdone), .data_mode_i(dmode),
		.double_speed_i(dspeed), .standby_time_set_i(tset), .standby_time_i(tval),
		.resp_read_i(rread), .play_end_clr_i(pe_clr), .buffer_full_clr_i(bf_clr),
		.subcode_q_clr_i(sq_clr), .status_code_o(st), .frame_address_o(fad),
		.repeat_count_o(rep), .periodic_valid_o(valid), .resp_pending_o(play_end_flag),
		.play_end_flag_o(pef), .buffer_full_flag_o(bff), .subcode_q_ready_flag_o(sqf),
		.double_rate_o(drate), .motor_on_o(motor));
	cd_host_drive_model u_host (.clock_i(clock_i), .rst_b_i(rst_b_i), .seek_kick_i(kick),
		.lat_i(lat), .resp_pending_i(play_end_flag), .auto_read_i(auto_rd), .seek_done_o(sdone),
		.resp_read_o(rread));
	function automatic logic [23:0] after_end(input logic [23:0] e);
		return e + 24'h000001;
	endfunction
	function automatic int sby_cyc(input logic [15:0] s);
		return (s == 16'h0000 ? 180 : int'(s)) * SEC;
	endfunction
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		$display("comparisons %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge clock_i);
	endtask
	task automatic cmd(input int k);
		cmd_v[k] = 1'b1;
		cyc(1);
		cmd_v = 6'h00;
	endtask
	task automatic pulse_max(input logic [3:0] m);
		mrep = m;
		mset = 1'b1;
		cyc(1);
		mset = 1'b0;
	endtask
	task automatic seek_wait;
		lat = 8'($urandom_range(1, 20));
		kick = 1'b1;
		cyc(1);
		kick = 1'b0;
		cyc(int'(lat) + 4);
	endtask
	task automatic reads(input int k);
		repeat (k) begin
			sread = 1'b1;
			cyc(1);
			sread = 1'b0;
			cyc(1);
		end
	endtask
	task automatic report(input logic [3:0] s, input logic [23:0] f);
		cyc(2 * OTH + 10);
		check(st, s);
		check(fad, f);
	endtask
	task automatic clear_end;
		pe_clr = 1'b1;
		cyc(1);
		pe_clr = 1'b0;
	endtask
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	initial begin
		#300000;
		failures++;
		conclude();
	end
	initial begin
		{rst_b_i, rset, mset, sread, bfull, dmode, dspeed, tset, pe_clr, bf_clr} = '0;
		{sq_clr, kick, cmd_v, rs, re, sfad, mrep, tval, lat} = '0;
		auto_rd = 1'b1;
		failures = 0;
		n_tests = 0;
		void'($urandom(32'h00b3));
		cyc(16);
		rst_b_i = 1'b1;
		// reset values are read before any edge: the first slot refreshes straight away
		check(st, 4'h2);
		check(fad, 24'hffffff);
		check(rep, 4'hf);
		check({valid, play_end_flag, pef, bff, sqf, motor}, 6'h00);
		check(drate, 1'b1);
		cyc(2);
		check(drate, 1'b0);
		check(fad, 24'hffffff);
		dmode = 1'b1;
		cyc(2);
		check(drate, 1'b1);
		dmode = 1'b0;
		cmd(1);
		seek_wait();
		pulse_max(4'h1);
		report(4'h1, 24'h000096);
		check(rep, 4'h0);
		for (int it = 0; it < 4; it++) begin
			len = $urandom_range(1, 6);
			rs = 24'($urandom_range(24'h000100, 24'h3ffff0));
			re = rs + 24'(len);
			dspeed = it[0] & ~it[1];
			dmode = it[0] & it[1];
			auto_rd = 1'b0;
			rset = 1'b1;
			cmd(0);
			rset = 1'b0;
			seek_wait();
			cyc(2 * OTH + 10);
			check(valid, 1'b0);
			check(st, 4'h1);
			check(play_end_flag, 1'b1);
			auto_rd = 1'b1;
			report(4'h3, rs);
			check(rep, 4'h1);
			sq_clr = 1'b1;
			cyc(1);
			sq_clr = 1'b0;
			n = 0;
			while (sqf !== 1'b1 && n < 200) begin
				cyc(1);
				n++;
			end
			check(n <= (it[0] ? DBL : STD) + 2, 1'b1);
			if (it[1]) begin
				pulse_max(4'h1);
				reads(len + 1);
				check(pef, 1'b0);
				seek_wait();
				report(4'h3, rs);
				check(rep, 4'h1);
			end
			reads(len);
			report(4'h3, re);
			reads(1);
			check(pef, 1'b1);
			report(4'h1, after_end(re));
			check(rep, 4'h1);
			clear_end();
			check(pef, 1'b0);
		end
		{dspeed, dmode} = 2'b00;
		pulse_max(4'hf);
		cmd(0);
		seek_wait();
		repeat (16) begin
			reads(len + 1);
			seek_wait();
		end
		report(4'h3, rs);
		check(rep, 4'he);
		pulse_max(4'h0);
		sfad = 24'h000050;
		cmd(2);
		seek_wait();
		check(pef, 1'b1);
		report(4'h1, sfad);
		clear_end();
		cmd(3);
		cyc(2);
		check(pef, 1'b1);
		clear_end();
		rs = 24'h000060;
		re = 24'h000080;
		rset = 1'b1;
		cmd(0);
		rset = 1'b0;
		report(4'h1, sfad);
		check(pef, 1'b1);
		pulse_max(4'h1);
		cmd(0);
		seek_wait();
		report(4'h3, rs);
		cmd(0);
		report(4'h3, rs);
		reads(2);
		bfull = 1'b1;
		cyc(1);
		bfull = 1'b0;
		cyc(1);
		check(bff, 1'b1);
		bf_clr = 1'b1;
		cyc(1);
		bf_clr = 1'b0;
		check(bff, 1'b0);
		report(4'h1, 24'h000062);
		tval = 16'h003c;
		tset = 1'b1;
		cyc(1);
		tval = 16'hffff;
		cyc(1);
		tset = 1'b0;
		cyc(sby_cyc(16'h003c) - 400);
		report(4'h1, 24'h000062);
		cyc(600);
		report(4'h2, 24'h000062);
		cmd(4);
		cyc(2);
		check(motor, 1'b0);
		report(4'h0, 24'hffffff);
		seek_wait();
		report(4'h2, 24'hffffff);
		check(rep, 4'hf);
		cmd(1);
		seek_wait();
		report(4'h1, 24'h000096);
		check(rep, 4'h1);
		cmd(5);
		report(4'h2, 24'h000096);
		conclude();
	end
endmodule
